// ### autoreload_pwm.sv
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
module autoreload_pwm
   import arpwm_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_cyc_i,
   output logic             wb_ack_o,
   input  wire logic        break_pin,
   input  wire logic        cmp_out,
   output logic      [3:0]  pulse_output
);
   import arpwm_pkg::*;

   st_t         s;        // present state
   st_t         next_s;   // next state
   logic        wr;       // write taken this edge
   logic [31:0] wm;       // byte-lane mask
   logic [31:0] wd;       // write data, lane-gated
   logic        ov1;      // counter one overflow
   logic        ov2;      // counter two overflow
   logic        detect;   // break level seen
   logic        brk1;     // break on counter one group
   logic        brk2;     // break on counter two group
   logic        dtz;      // dead time on with zero count

   ////////////////////////////////////////////////////////////
   // merge written lanes over an old value
   // the mask follows wb_sel_i, so a narrow write keeps the other lanes
   function automatic logic [31:0] merge(input logic [31:0] old);
      merge = (old & ~wm) | wd;
   endfunction

   ////////////////////////////////////////////////////////////
   // decoded events, used by both the update and the checks
   always_comb begin
      wm  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      wd  = wb_dat_i & wm;
      // write lands on the edge where the master sees ack
      wr  = s.ack & wb_cyc_i & wb_stb_i & wb_we_i;
      ov1 = (s.cnt1 == cnt_max) | (wr & (wb_adr_i == a_ctrl) & wd[b_frc1]);
      ov2 = s.dual & ((s.cnt2 == cnt_max) | (wr & (wb_adr_i == a_ctrl) & wd[b_frc2]));
      detect = s.break_function_enable & ((s.bsel ? s.cmp_lv : s.pin_lv) == s.blvl);
      brk1 = s.break_function_enable & s.bact & s.g1;
      brk2 = s.break_function_enable & s.bact & (s.dual ? s.g2 : s.g1);
      dtz  = s.dt_act[b_dte] & (s.dt_act[6:0] == 7'h00);
   end

   ////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      logic       c2;   // channel follows counter two
      logic       ovi;  // overflow of channel's counter
      logic       tri_; // transfer bit of channel's counter
      logic [11:0] ci;  // channel's counter value
      logic       v;    // composed pin level
      logic [31:0] m;   // written lanes over the old value
      c2   = 1'b0;
      ovi  = 1'b0;
      tri_ = 1'b0;
      ci   = 12'h000;
      v    = 1'b0;
      m    = 32'h00000000;
      next_s = s;

      // synchronisers: a level counts once stages two and three agree
      next_s.sy_pin = {s.sy_pin[1:0], break_pin};
      next_s.sy_cmp = {s.sy_cmp[1:0], cmp_out};
      if (s.sy_pin[1] == s.sy_pin[2]) begin
         next_s.pin_lv = s.sy_pin[2];
      end
      if (s.sy_cmp[1] == s.sy_cmp[2]) begin
         next_s.cmp_lv = s.sy_cmp[2];
      end

      // bus: one ack per request, dropped the cycle after
      next_s.ack = wb_cyc_i & wb_stb_i & ~s.ack;
      unique case (wb_adr_i)
         a_ctrl:  next_s.rdat = {27'h0000000, 2'b00, s.tr2, s.tr1, s.dual};
         a_arr1:  next_s.rdat = {20'h00000, s.arr1};
         a_arr2:  next_s.rdat = {20'h00000, s.arr2};
         a_duty0: next_s.rdat = {20'h00000, s.dpre[0]};
         a_duty1: next_s.rdat = {20'h00000, s.dpre[1]};
         a_duty2: next_s.rdat = {20'h00000, s.dpre[2]};
         a_duty3: next_s.rdat = {20'h00000, s.dpre[3]};
         a_oe:    next_s.rdat = {24'h000000, s.pol_pre, s.oe};
         a_dt:    next_s.rdat = {24'h000000, s.dt_pre};
         a_brk:   next_s.rdat = {24'h000000, s.bpat, s.bact, s.blvl, s.break_function_enable, s.bsel};
         a_gate:  next_s.rdat = {30'h00000000, s.g2, s.g1};
         // live counters show the block's own state
         a_cnt:   next_s.rdat = {4'h0, s.cnt2, 4'h0, s.cnt1};
         // unmapped offsets answer with zero
         default: next_s.rdat = 32'h00000000;
      endcase

      // transfer bits clear once used; a software set still wins
      if (ov1 & s.tr1) begin
         next_s.tr1 = 1'b0;
      end
      if (ov2 & s.tr2) begin
         next_s.tr2 = 1'b0;
      end

      // register writes; a field takes only the byte lanes that were selected
      // merging into a temporary keeps every bit-select on a plain variable
      if (wr) begin
         unique case (wb_adr_i)
            a_ctrl: begin
               m           = merge({31'h00000000, s.dual});
               next_s.dual = m[b_dual];
               // transfer bits are write-one-to-set
               if (wd[b_tr1]) begin
                  next_s.tr1 = 1'b1;
               end
               if (wd[b_tr2]) begin
                  next_s.tr2 = 1'b1;
               end
            end
            a_arr1: begin
               m           = merge({20'h00000, s.arr1});
               next_s.arr1 = m[11:0];
            end
            a_arr2: begin
               m           = merge({20'h00000, s.arr2});
               next_s.arr2 = m[11:0];
            end
            a_duty0: begin
               m              = merge({20'h00000, s.dpre[0]});
               next_s.dpre[0] = m[11:0];
            end
            a_duty1: begin
               m              = merge({20'h00000, s.dpre[1]});
               next_s.dpre[1] = m[11:0];
            end
            a_duty2: begin
               m              = merge({20'h00000, s.dpre[2]});
               next_s.dpre[2] = m[11:0];
            end
            a_duty3: begin
               m              = merge({20'h00000, s.dpre[3]});
               next_s.dpre[3] = m[11:0];
            end
            a_oe: begin
               // enables act at once, polarity waits for a transfer
               m              = merge({24'h000000, s.pol_pre, s.oe});
               next_s.oe      = m[3:0];
               next_s.pol_pre = m[7:4];
            end
            a_dt: begin
               m             = merge({24'h000000, s.dt_pre});
               next_s.dt_pre = m[7:0];
            end
            a_brk: begin
               m           = merge({24'h000000, s.bpat, s.bact, s.blvl, s.break_function_enable, s.bsel});
               next_s.bsel = m[b_bsel];
               next_s.break_function_enable = m[b_break_function_enable];
               next_s.blvl = m[b_blvl];
               next_s.bact = m[b_bact];
               next_s.bpat = m[7:4];
            end
            a_gate: begin
               m         = merge({30'h00000000, s.g2, s.g1});
               next_s.g1 = m[b_g1];
               next_s.g2 = m[b_g2];
            end
            default: begin
               // unmapped write is acknowledged and dropped
            end
         endcase
      end

      // hardware set wins over a software clear
      if (detect) begin
         next_s.bact = 1'b1;
      end

      // counters
      if (brk1 | brk2) begin
         // gated counters cleared, all counters frozen
         if (brk1) begin
            next_s.cnt1 = 12'h000;
         end
         if (brk2) begin
            next_s.cnt2 = 12'h000;
         end
      end else begin
         // count from reload to max, period 4096 minus reload
         next_s.cnt1 = ov1 ? s.arr1 : s.cnt1 + 12'h001;
         if (s.dual) begin
            next_s.cnt2 = ov2 ? s.arr2 : s.cnt2 + 12'h001;
         end else begin
            next_s.cnt2 = 12'h000;
         end
      end

      // per-channel duty transfer and waveform
      for (int i = 0; i < nch; i++) begin
         // upper pair moves to counter two in dual mode
         c2   = (i >= 2) & s.dual;
         ovi  = c2 ? ov2 : ov1;
         // transfer bit of the owning counter
         tri_ = c2 ? s.tr2 : s.tr1;
         ci   = c2 ? s.cnt2 : s.cnt1;
         if (!(brk1 | brk2)) begin
            if (ovi & tri_) begin
               next_s.dact[i]    = s.dpre[i];
               next_s.pol_act[i] = s.pol_pre[i];
            end
            // high at overflow, low at match
            if (ovi) begin
               next_s.raw[i] = 1'b1;
            end else if (ci == s.dact[i]) begin
               next_s.raw[i] = 1'b0;
            end
         end
      end

      // dead-time engine on outputs zero and one
      if (!(brk1 | brk2)) begin
         if (ov1) begin
            next_s.dt_act = s.dt_pre;
            // ch1 falls now, ch0 rises after delay
            next_s.d1     = 1'b0;
            next_s.dt_cnt = s.dt_pre[6:0];
            next_s.dt_tgt = 1'b0;
            next_s.dt_run = 1'b1;
         end else if (s.cnt1 == s.dact[0]) begin
            // ch0 falls at match, ch1 rises after delay
            next_s.d0     = 1'b0;
            next_s.dt_cnt = s.dt_act[6:0];
            next_s.dt_tgt = 1'b1;
            next_s.dt_run = 1'b1;
         end else if (s.dt_run) begin
            // delay of count clock cycles
            if (s.dt_cnt <= 7'h01) begin
               next_s.dt_run = 1'b0;
               if (s.dt_tgt) begin
                  next_s.d1 = 1'b1;
               end else begin
                  next_s.d0 = 1'b1;
               end
            end else begin
               next_s.dt_cnt = s.dt_cnt - 7'h01;
            end
         end
      end

      // reload and duty values return to reset
      // software must rewrite reloads and duties before leaving a break
      if (brk1 | brk2) begin
         next_s.arr1 = 12'h000;
         next_s.arr2 = 12'h000;
         next_s.dpre = '0;
         next_s.dact = '0;
      end

      // pin composition, registered
      for (int i = 0; i < nch; i++) begin
         v = s.raw[i];
         if (s.dt_act[b_dte] && i < 2) begin
            v = (i == 0) ? s.d0 : s.d1;
         end
         // inversion after dead time may overlap
         v = v ^ s.pol_act[i];
         // zero count holds pins at reset level
         if (dtz) begin
            v = 1'b0;
         end
         if ((i < 2) ? brk1 : brk2) begin
            v = s.bpat[i];
         end
         next_s.pwm[i] = v & s.oe[i];
      end
   end

   ////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s     <= '0;
         s.tr1 <= tr_rst;
         s.tr2 <= tr_rst;
      end else begin
         s <= next_s;
      end
   end

   assign wb_ack_o     = s.ack;
   assign wb_dat_o     = s.rdat;
   assign pulse_output = s.pwm;

   ////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   chk_cnt_reload: assert property ((s.cnt1 == cnt_max && !(brk1 | brk2)) |=> s.cnt1 == $past(s.arr1))
      else $error("counter one did not reload");
   chk_duty_xfer: assert property ((ov1 && s.tr1 && !(brk1 | brk2)) |=> s.dact[0] == $past(s.dpre[0]))
      else $error("duty transfer missed");
   chk_no_xfer: assert property ((ov1 && !s.tr1 && !(brk1 | brk2) && !s.dual) |=> $stable(s.dact[3]))
      else $error("duty moved without transfer bit");
   // waveform checks leave out cycles in which a break overrides the pins
   chk_pwm_rise: assert property ((ov1 && !(brk1 | brk2)) |=> s.raw[0])
      else $error("output not set at overflow");
   chk_pin_polarity: assert property ((!(brk1 | brk2) && !dtz && !s.dt_act[b_dte]) |=> pulse_output[0] ==
      ($past(s.oe[0]) & ($past(s.raw[0]) ^ $past(s.pol_act[0]))))
      else $error("pin does not follow waveform and polarity");
   chk_pwm_fall: assert property ((!ov1 && s.cnt1 == s.dact[1] && !(brk1 | brk2)) |=> !s.raw[1])
      else $error("output not cleared at match");
   chk_dual_route: assert property ((s.dual && ov2 && !ov1 && !(brk1 | brk2)) |=> s.raw[2] && s.raw[3])
      else $error("upper pair not on counter two");
   chk_oe_off: assert property ((!s.oe[1]) |=> !pulse_output[1])
      else $error("disabled output driven");
   chk_break_pat: assert property ((brk1 && s.oe[0]) |=> pulse_output[0] == $past(s.bpat[0]))
      else $error("break pattern not applied");
   chk_break_clear: assert property (brk1 |=> s.cnt1 == 12'h000 && s.arr1 == 12'h000 && s.dact[0] == 12'h000)
      else $error("break did not clear timer");
   chk_break_set: assert property (detect |=> s.bact)
      else $error("break flag not set");
   chk_dt_zero: assert property ((dtz && !(brk1 | brk2)) |=> pulse_output == 4'h0)
      else $error("zero dead time did not hold pins");
   chk_dt_delay: assert property ((ov1 && !s.d0 && !(brk1 | brk2) && s.dt_pre[6:0] == 7'h03) |=> !s.d0 [*3])
      else $error("dead time too short");
   chk_ack_once: assert property (s.ack |=> !s.ack)
      else $error("ack held two cycles");

   cov_xfer:  cover property (ov1 && s.tr1);
   cov_break: cover property (brk1 && s.oe[0]);
   cov_dead:  cover property (s.dt_run && s.dt_tgt);
   cov_dual:  cover property (s.dual && ov2);
endmodule

// ### arpwm_pkg.sv
package arpwm_pkg;
   // counter geometry
   localparam int          cw       = 12;
   localparam logic [11:0] cnt_max  = 12'hfff;
   localparam int          nch      = 4;
   // register byte offsets
   localparam logic [7:0]  a_ctrl   = 8'h00;
   localparam logic [7:0]  a_arr1   = 8'h04;
   localparam logic [7:0]  a_arr2   = 8'h08;
   localparam logic [7:0]  a_duty0  = 8'h0c;
   localparam logic [7:0]  a_duty1  = 8'h10;
   localparam logic [7:0]  a_duty2  = 8'h14;
   localparam logic [7:0]  a_duty3  = 8'h18;
   localparam logic [7:0]  a_oe     = 8'h1c;
   localparam logic [7:0]  a_dt     = 8'h20;
   localparam logic [7:0]  a_brk    = 8'h24;
   localparam logic [7:0]  a_gate   = 8'h28;
   localparam logic [7:0]  a_cnt    = 8'h2c;
   // control register fields
   localparam int          b_dual   = 0;
   localparam int          b_tr1    = 1;
   localparam int          b_tr2    = 2;
   localparam int          b_frc1   = 3;
   localparam int          b_frc2   = 4;
   // output register: enables low nibble, polarity high nibble
   localparam int          b_pol    = 4;
   // dead-time register: enable on top bit, count below
   localparam int          b_dte    = 7;
   // break control fields
   localparam int          b_bsel   = 0;
   localparam int          b_break_function_enable   = 1;
   localparam int          b_blvl   = 2;
   localparam int          b_bact   = 3;
   localparam int          b_bpat   = 4;
   // break gate fields
   localparam int          b_g1     = 0;
   localparam int          b_g2     = 1;
   // counter read-back: counter two position
   localparam int          b_cnt2   = 16;
   // reset values
   localparam logic        tr_rst   = 1'b1;

   // whole state of the timer
   typedef struct packed {
      logic [2:0]           sy_pin;   // break pin synchroniser
      logic [2:0]           sy_cmp;   // comparator synchroniser
      logic                 pin_lv;   // filtered pin level
      logic                 cmp_lv;   // filtered comparator level
      logic                 dual;     // second_counter_enable
      logic                 tr1;      // transfer_first_counter
      logic                 tr2;      // transfer_second_counter
      logic [11:0]          arr1;     // autoreload_first
      logic [11:0]          arr2;     // autoreload_second
      logic [11:0]          cnt1;     // counter_one
      logic [11:0]          cnt2;     // counter_two
      logic [3:0][11:0]     dpre;     // preload duty values
      logic [3:0][11:0]     dact;     // active duty values
      logic [3:0]           oe;       // output gate bits
      logic [3:0]           pol_pre;  // polarity written
      logic [3:0]           pol_act;  // polarity in use
      logic [3:0]           raw;      // uninverted waveforms
      logic                 d0;       // dead-time output zero
      logic                 d1;       // dead-time output one
      logic [7:0]           dt_pre;   // dead_time_reg as written
      logic [7:0]           dt_act;   // dead_time_reg in use
      logic [6:0]           dt_cnt;   // dead-time down counter
      logic                 dt_tgt;   // edge waiting: 0 ch0, 1 ch1
      logic                 dt_run;   // dead-time delay running
      logic                 bsel;     // break_source_select
      logic                 break_function_enable;     // break_function_enable
      logic                 blvl;     // break_level_select
      logic                 bact;     // break-active flag
      logic [3:0]           bpat;     // break pattern
      logic                 g1;       // break_gate_first
      logic                 g2;       // break_gate_second
      logic [3:0]           pwm;      // registered pins
      logic                 ack;      // bus acknowledge
      logic [31:0]          rdat;     // bus read data
   } st_t;
endpackage

// ### power_stage.sv
`timescale 1ns/10ps
// half-bridge leg model fed by the pulse pins
module power_stage (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic [3:0] gate_drive,
   output logic            overcurrent
);
   ////////////////////////////////////////////////////////////////////////////
   // current sense comparator, registered like a real sense path
   // overlap trips sense
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         overcurrent <= 1'b0;
      end else begin
         // both switches of leg zero on means shoot-through
         overcurrent <= gate_drive[0] & gate_drive[1];
      end
   end
endmodule

// ### testbench.sv
`timescale 1ns/10ps
module testbench;
   import arpwm_pkg::*;
   logic        core_clk = 0;                  // 40 MHz clock
   logic        rstn = 0;                      // async reset
   logic [7:0]  wb_adr_i = 8'h00;              // bus address
   logic [31:0] wb_dat_i = 32'h0;              // write data
   logic [3:0]  wb_sel_i = 4'h0;               // byte lanes
   logic        wb_we_i = 0;                   // direction
   logic        wb_stb_i = 0;                  // strobe
   logic        wb_cyc_i = 0;                  // cycle
   logic        break_pin = 0;                 // external break
   logic [31:0] wb_dat_o;                      // read data
   logic        wb_ack_o;                      // acknowledge
   logic [3:0]  pulse_output;                  // pins
   logic        cmp_out;                       // from power stage
   logic [31:0] rq[$];                         // expected read data
   logic [31:0] pq[$];                         // expected pin levels
   int          wq[$];                         // expected high, period
   int err_count = 0, n_tests = 0, seed = 39, wch = 0, skip = 0, hi = 0, run = 0;
   logic [3:0]  prv = 4'h0;                    // last pin levels
   int          h[4];                          // expected high widths
   logic [31:0] r;                             // random word

   always #12.5 core_clk = ~core_clk;

   autoreload_pwm DUT (.core_clk(core_clk), .rstn(rstn), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i),
      .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .break_pin(break_pin), .cmp_out(cmp_out),
      .pulse_output(pulse_output));
   power_stage stage (.core_clk(core_clk), .rstn(rstn), .gate_drive(pulse_output), .overcurrent(cmp_out));

   ////////////////////////////////////////////////////////////////////////////
   // compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (e !== g) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watcher: read data at ack, pins on request, widths between rises
   always @(posedge core_clk) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0) chk("rdata", rq.pop_front(), wb_dat_o);
      if (pq.size() > 0) chk("pins", pq.pop_front(), {28'h0, pulse_output});
      prv <= pulse_output;
      run <= run + 1;
      if (pulse_output[wch] === 1'b1 && prv[wch] === 1'b0) begin
         // first rises after a change may still show the old setting
         if (skip > 0) skip <= skip - 1;
         else if (wq.size() > 1) begin
            chk("high", wq.pop_front(), hi);
            chk("period", wq.pop_front(), run);
         end
         hi <= 1;
         run <= 1;
      end else if (pulse_output[wch] === 1'b1) hi <= hi + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // classic single-cycle master, waits for ack under a bound
   task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [31:0] e);
      int n;
      n = 0;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_we_i <= w;
      wb_sel_i <= 4'hf;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      if (!w) rq.push_back(e);
      do begin
         @(posedge core_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) chk("ack", 1, 0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge core_clk);
   endtask

   // note one waveform and wait until the watcher has judged it
   task automatic wave(input int c, input int hh, input int p);
      @(negedge core_clk);
      wch = c;
      skip = 2;
      wq.push_back(hh);
      wq.push_back(p);
      for (int i = 0; i < 300 && wq.size() > 0; i++) @(posedge core_clk);
      if (wq.size() > 0) begin
         chk("wave", 1, 0);
         wq.delete();
      end
   endtask

   task automatic pins(input int wt, input logic [3:0] e);
      repeat (wt) @(posedge core_clk);
      @(negedge core_clk);
      pq.push_back({28'h0, e});
      @(posedge core_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      wb(a_ctrl, 0, 0, 32'h6);
      wb(8'h30, 32'hffffffff, 1, 0);
      wb(8'h30, 0, 0, 32'h0);
      wb(a_arr1, 32'hfffffff0, 1, 0);
      wb(a_arr1, 0, 0, 32'h00000ff0);
      wb(a_duty0, 32'hff8, 1, 0);
      wb(a_oe, 32'h0f, 1, 0);
      wb(a_ctrl, 32'ha, 1, 0);
      wave(0, 9, 16);
      wb(a_duty0, 32'hffc, 1, 0);
      wave(0, 9, 16);
      wb(a_ctrl, 32'h2, 1, 0);
      wave(0, 13, 16);
      for (int c = 0; c < 4; c++) begin
         r = $random(seed);
         h[c] = r[2:0] + 2;
         wb(a_duty0 + 8'(4 * c), {20'h0, 12'hff1 + {9'h0, r[2:0]}}, 1, 0);
         wb(a_ctrl, 32'h2, 1, 0);
         wave(c, h[c], 16);
      end
      wb(a_oe, 32'h1f, 1, 0);
      wb(a_ctrl, 32'h2, 1, 0);
      wave(0, 16 - h[0], 16);
      wb(a_arr2, 32'hff8, 1, 0);
      wb(a_duty2, 32'hffc, 1, 0);
      wb(a_ctrl, 32'h5, 1, 0);
      wb(a_ctrl, 32'h15, 1, 0);
      wave(2, 5, 8);
      wave(0, 16 - h[0], 16);
      wb(a_ctrl, 32'h2, 1, 0);
      wave(2, 13, 16);
      wb(a_oe, 32'h0f, 1, 0);
      wb(a_duty0, 32'hff8, 1, 0);
      wb(a_dt, 32'h83, 1, 0);
      wb(a_ctrl, 32'h2, 1, 0);
      wave(0, 6, 16);
      wave(1, 4, 16);
      wb(a_dt, 32'h80, 1, 0);
      pins(40, 4'h0);
      wb(a_dt, 32'h0, 1, 0);
      wb(a_gate, 32'h1, 1, 0);
      wb(a_brk, 32'ha4, 1, 0);
      break_pin <= 1'b1;
      repeat (12) @(posedge core_clk);
      wb(a_brk, 0, 0, 32'ha4);
      wb(a_brk, 32'ha6, 1, 0);
      pins(12, 4'ha);
      wb(a_brk, 0, 0, 32'hae);
      wb(a_arr1, 0, 0, 32'h0);
      wb(a_duty0, 0, 0, 32'h0);
      break_pin <= 1'b0;
      repeat (12) @(posedge core_clk);
      wb(a_brk, 32'h56, 1, 0);
      wb(a_brk, 32'h5e, 1, 0);
      pins(4, 4'h5);
      wb(a_brk, 32'h56, 1, 0);
      pins(8, 4'h0);
      wb(a_arr1, 32'hff0, 1, 0);
      wb(a_duty0, 32'hff8, 1, 0);
      wb(a_duty1, 32'hff8, 1, 0);
      wb(a_oe, 32'h33, 1, 0);
      wb(a_dt, 32'h83, 1, 0);
      wb(a_ctrl, 32'ha, 1, 0);
      wb(a_brk, 32'h07, 1, 0);
      repeat (60) @(posedge core_clk);
      wb(a_brk, 0, 0, 32'h0f);
      pins(2, 4'h0);
      complete_run();
   end

   // watchdog well beyond the expected run length
   initial begin
      #(25.0 * 40000);
      err_count++;
      complete_run();
   end
endmodule
